/* File: rtl/tsrc_pkg.sv */
// Shared constants and types for the timer, tick counter and soft reset register block.
// Behaviour
// R1 - Timer runs while its run-enable bit is one, halts while zero.
// R2 - Run-enable falling edge forces the timer preload field to all ones.
// R3 - On enabling, timer starts at the preload value and counts down.
// R4 - Timer raises a periodic host interrupt event set by the preload; here only the first period uses it, later ones are 65536 ticks.
// R5 - Live timer value is readable, read-only, and resets to all ones.
// R6 - Tick counter clears at reset and increments every 25MHz cycle.
// R7 - Tick counter wraps from maximum to zero and keeps counting.
// R8 - Tick counter reaches zero within 160nS after a reset event.
// R9 - Virtual PHY reset bit resets the virtual PHY and clears on release.
// R10 - Writes to a self-clearing reset bit are ignored while it reads one.
// R11 - Port PHY reset bits hold that PHY in reset at least 102uS.
// R12 - The configuration loader cannot write any software reset bit.
// R13 - Core reset bit resets the chip except PLL and the three PHYs.
// R14 - After core reset the loader reloads configuration without PHY resets.
// R15 - Core reset returns system registers to defaults except surviving bits.
// R16 - Core reset aborts any configuration-memory command in progress.
// R17 - Core reset bit clears itself when the chip leaves that reset.
// R18 - Host polls the byte-order probe register to see reset completion.
// R19 - Reset control register stays readable while not ready or in reset.
// R20 - Either 16-bit half of a register can be read alone.
// R21 - Byte-order probe reads a fixed pattern once access is valid.
// R22 - Ready status sets only once the device is stable after any reset.
// R23 - Running timer wraps from zero to all ones and flags an event.
package tsrc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_BYTE_PROBE = 12'h064;
  localparam logic [11:0] OFS_HW_CONFIG = 12'h074;
  localparam logic [11:0] OFS_TIMER_CONFIG = 12'h08C;
  localparam logic [11:0] OFS_TIMER_COUNT = 12'h090;
  localparam logic [11:0] OFS_TICK_COUNTER = 12'h09C;
  localparam logic [11:0] OFS_SOFT_RESET = 12'h1F8;

  localparam logic [31:0] BYTE_PROBE_VALUE = 32'h87654321;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
  localparam int READY_BIT = 27;
  localparam int TIMER_EN_BIT = 29;
  localparam int VPHY_BIT = 3;
  localparam int PHY2_BIT = 2;
  localparam int PHY1_BIT = 1;
  localparam int CORE_BIT = 0;

  localparam logic [15:0] TIMER_RESET = 16'hFFFF;
  localparam logic [15:0] TIMER_ZERO = 16'h0000;
  localparam logic [31:0] TICK_RESET = 32'h00000000;

  localparam int CLK_PERIOD_PS = 4000;
  localparam int TICK_PERIOD_PS = 40000;
  localparam int TICK_DIV = TICK_PERIOD_PS / CLK_PERIOD_PS;
  localparam int TICK_CLEAR_MAX_NS = 160;
  localparam int TICK_CLEAR_MAX_CYC = (TICK_CLEAR_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int PHY_HOLD_US = 102;
  localparam int PHY_HOLD_CYC = (PHY_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TIMER_DIV_DEFAULT = 250;
  localparam int VPHY_HOLD_DEFAULT = 16;
  localparam int CORE_HOLD_DEFAULT = 32;
  localparam int READY_CNT_W = 8;
  localparam logic [7:0] READY_DELAY = 8'h20;
  localparam logic [7:0] READY_CNT_ZERO = 8'h00;

  typedef struct packed {
    logic timerEn;
    logic [15:0] preload;
    logic [15:0] count;
    logic [31:0] tickCount;
    logic vphyReq;
    logic phy1Req;
    logic phy2Req;
    logic coreReq;
    logic timerEvent;
    logic abortPulse;
    logic reloadPulse;
    logic ready;
    logic [READY_CNT_W-1:0] readyCnt;
    logic ack;
    logic [31:0] rdata;
  } tsrc_state_t;
endpackage

/* File: rtl/tsrc_hold_if.sv */
// Handshake between the register logic and one reset hold timer.
`timescale 1ns/1ps
interface tsrc_hold_if;
  logic start;
  logic active;
  logic done;
  modport ctrl (output start, input active, input done);
  modport hold (input start, output active, output done);
endinterface

/* File: rtl/tsrc_tick_div.sv */
// Clock divider that emits a one-cycle enable pulse every DIV cycles.
`timescale 1ns/1ps
module tsrc_tick_div #(
  parameter int DIV = 10
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic tick
);
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } tsrc_div_t;

  tsrc_div_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == LAST) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

/* File: rtl/tsrc_hold_timer.sv */
// Holds a reset asserted for a fixed number of cycles after a start pulse.
`timescale 1ns/1ps
module tsrc_hold_timer #(
  parameter int HOLD = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  tsrc_hold_if.hold hif
);
  localparam int CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] FIRST = CW'(HOLD - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  typedef struct packed {
    logic active;
    logic done;
    logic [CW-1:0] cnt;
  } tsrc_hold_t;

  tsrc_hold_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!s_q.active) begin
      if (hif.start) begin
        s_d.active = 1'b1;
        s_d.cnt = FIRST;
      end
    end else if (s_q.cnt == '0) begin
      s_d.active = 1'b0;
      s_d.done = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt - ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hif.active = s_q.active;
  assign hif.done = s_q.done;
endmodule

/* File: rtl/tsrc_regs.sv */
// Timer, free-running tick counter and self-clearing soft reset register bank.
`timescale 1ns/1ps
module tsrc_regs
  import tsrc_pkg::*;
#(
  parameter int PHY_HOLD = PHY_HOLD_CYC,
  parameter int VPHY_HOLD = VPHY_HOLD_DEFAULT,
  parameter int CORE_HOLD = CORE_HOLD_DEFAULT,
  parameter int TIMER_DIV = TIMER_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic regLoader,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [1:0] regHalf,
  input wire logic [31:0] regWdata,
  output logic regAck,
  output logic [31:0] regRdata,
  output logic timerEvent,
  output logic vphyResetOut,
  output logic phy1ResetOut,
  output logic phy2ResetOut,
  output logic coreResetOut,
  output logic loaderAbort,
  output logic loaderReload,
  output logic deviceReady
);
  tsrc_state_t s_q, s_d;
  logic tick25;
  logic timerTick;
  logic [31:0] wmask;
  logic [31:0] readWord;
  logic [31:0] cfgWord;
  logic [31:0] ctlWord;
  logic hostWr;
  logic newEn;

  tsrc_hold_if vphyIf ();
  tsrc_hold_if phy1If ();
  tsrc_hold_if phy2If ();
  tsrc_hold_if coreIf ();

  tsrc_tick_div #(.DIV(TICK_DIV)) tickDiv (
    .clk(clk),
    .rst_b(rst_b),
    .tick(tick25)
  );

  tsrc_tick_div #(.DIV(TIMER_DIV)) timerDiv (
    .clk(clk),
    .rst_b(rst_b),
    .tick(timerTick)
  );

  tsrc_hold_timer #(.HOLD(VPHY_HOLD)) vphyHold (
    .clk(clk),
    .rst_b(rst_b),
    .hif(vphyIf.hold)
  );

  tsrc_hold_timer #(.HOLD(PHY_HOLD)) phy1Hold (
    .clk(clk),
    .rst_b(rst_b),
    .hif(phy1If.hold)
  );

  tsrc_hold_timer #(.HOLD(PHY_HOLD)) phy2Hold (
    .clk(clk),
    .rst_b(rst_b),
    .hif(phy2If.hold)
  );

  tsrc_hold_timer #(.HOLD(CORE_HOLD)) coreHold (
    .clk(clk),
    .rst_b(rst_b),
    .hif(coreIf.hold)
  );

  always_comb begin
    wmask = {{16{regHalf[1]}}, {16{regHalf[0]}}};
    cfgWord = READ_ZERO;
    cfgWord[TIMER_EN_BIT] = s_q.timerEn;
    cfgWord[15:0] = s_q.preload;
    ctlWord = READ_ZERO;
    ctlWord[VPHY_BIT] = s_q.vphyReq;
    ctlWord[PHY2_BIT] = s_q.phy2Req;
    ctlWord[PHY1_BIT] = s_q.phy1Req;
    ctlWord[CORE_BIT] = s_q.coreReq;
    readWord = READ_ZERO;
    // R19 reads tolerated.
    unique case (regAddr)
      OFS_SOFT_RESET: readWord = ctlWord;
      // R21 probe pattern.
      OFS_BYTE_PROBE: readWord = s_q.ready ? BYTE_PROBE_VALUE : READ_ZERO;
      OFS_HW_CONFIG: readWord[READY_BIT] = s_q.ready;
      OFS_TIMER_CONFIG: readWord = cfgWord;
      // R5 live count.
      OFS_TIMER_COUNT: readWord[15:0] = s_q.count;
      OFS_TICK_COUNTER: readWord = s_q.tickCount;
      default: readWord = READ_ZERO;
    endcase
  end

  // Writes other than to the reset bits are dropped while the core is resetting or not ready.
  assign hostWr = regReq && regWrite && !regLoader;
  assign newEn = regHalf[1] ? regWdata[TIMER_EN_BIT] : s_q.timerEn;

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.timerEvent = 1'b0;
    s_d.abortPulse = 1'b0;
    s_d.reloadPulse = 1'b0;
    vphyIf.start = 1'b0;
    phy1If.start = 1'b0;
    phy2If.start = 1'b0;
    coreIf.start = 1'b0;

    if (regReq) begin
      s_d.ack = 1'b1;
      // R20 half selection.
      s_d.rdata = regWrite ? s_q.rdata : (readWord & wmask);
    end

    // R7 tick counter wraps.
    if (tick25) begin
      s_d.tickCount = s_q.tickCount + 32'h00000001;
    end

    // R1 timer runs.
    if (s_q.timerEn && timerTick) begin
      // R23 wrap and event.
      if (s_q.count == TIMER_ZERO) begin
        s_d.count = TIMER_RESET;
        // R4 interrupt event.
        s_d.timerEvent = 1'b1;
      end else begin
        s_d.count = s_q.count - 16'h0001;
      end
    end

    if (regReq && regWrite && s_q.ready && !coreIf.active &&
        regAddr == OFS_TIMER_CONFIG) begin
      if (regHalf[0]) begin
        s_d.preload = regWdata[15:0];
      end
      s_d.timerEn = newEn;
      // R3 start from preload.
      if (!s_q.timerEn && newEn) begin
        s_d.count = regHalf[0] ? regWdata[15:0] : s_q.preload;
      end
      // R2 preload forced.
      if (s_q.timerEn && !newEn) begin
        s_d.preload = TIMER_RESET;
      end
    end

    // R12 loader excluded.
    if (hostWr && regAddr == OFS_SOFT_RESET && regHalf[0]) begin
      // R10 ignore while set.
      if (!s_q.vphyReq && regWdata[VPHY_BIT]) begin
        s_d.vphyReq = 1'b1;
        vphyIf.start = 1'b1;
      end
      if (!s_q.phy1Req && regWdata[PHY1_BIT]) begin
        s_d.phy1Req = 1'b1;
        phy1If.start = 1'b1;
      end
      if (!s_q.phy2Req && regWdata[PHY2_BIT]) begin
        s_d.phy2Req = 1'b1;
        phy2If.start = 1'b1;
      end
      if (!s_q.coreReq && regWdata[CORE_BIT]) begin
        s_d.coreReq = 1'b1;
        coreIf.start = 1'b1;
        // R16 abort loader.
        s_d.abortPulse = 1'b1;
      end
    end

    // R9 clear on release.
    if (vphyIf.done) begin
      s_d.vphyReq = 1'b0;
    end
    // R11 hold then clear.
    if (phy1If.done) begin
      s_d.phy1Req = 1'b0;
    end
    if (phy2If.done) begin
      s_d.phy2Req = 1'b0;
    end

    if (s_q.ready == 1'b0 && !coreIf.active && !s_q.coreReq) begin
      if (s_q.readyCnt == READY_CNT_ZERO) begin
        s_d.ready = 1'b1;
      end else begin
        s_d.readyCnt = s_q.readyCnt - 8'h01;
      end
    end

    // R13 core reset scope.
    if (coreIf.active) begin
      // R15 defaults restored.
      s_d.timerEn = 1'b0;
      s_d.preload = TIMER_RESET;
      s_d.count = TIMER_RESET;
      s_d.timerEvent = 1'b0;
      // R8 tick clears fast.
      s_d.tickCount = TICK_RESET;
      // R22 not ready yet.
      s_d.ready = 1'b0;
      s_d.readyCnt = READY_DELAY;
    end

    if (coreIf.done) begin
      // R17 self clear.
      s_d.coreReq = 1'b0;
      // R14 reload config.
      s_d.reloadPulse = 1'b1;
    end
  end

  // The PHY reset outputs mirror the request bits, so one register serves both.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q.timerEn <= 1'b0;
      s_q.preload <= TIMER_RESET;
      s_q.count <= TIMER_RESET;
      // R6 clear at reset.
      s_q.tickCount <= TICK_RESET;
      s_q.vphyReq <= 1'b0;
      s_q.phy1Req <= 1'b0;
      s_q.phy2Req <= 1'b0;
      s_q.coreReq <= 1'b0;
      s_q.timerEvent <= 1'b0;
      s_q.abortPulse <= 1'b0;
      s_q.reloadPulse <= 1'b0;
      s_q.ready <= 1'b0;
      s_q.readyCnt <= READY_DELAY;
      s_q.ack <= 1'b0;
      s_q.rdata <= READ_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  assign regAck = s_q.ack;
  assign regRdata = s_q.rdata;
  assign timerEvent = s_q.timerEvent;
  assign vphyResetOut = s_q.vphyReq;
  assign phy1ResetOut = s_q.phy1Req;
  assign phy2ResetOut = s_q.phy2Req;
  assign coreResetOut = s_q.coreReq;
  assign loaderAbort = s_q.abortPulse;
  assign loaderReload = s_q.reloadPulse;
  assign deviceReady = s_q.ready;
endmodule

/* File: tb/tsrc_regs_properties.sv */
// Port-level checks for the access acknowledge and soft reset outputs of the register bank.
`timescale 1ns/1ps
module tsrc_regs_properties
  import tsrc_pkg::*;
#(
  parameter int PHY_HOLD = PHY_HOLD_CYC,
  parameter int VPHY_HOLD = VPHY_HOLD_DEFAULT,
  parameter int CORE_HOLD = CORE_HOLD_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic regLoader,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [1:0] regHalf,
  input wire logic [31:0] regWdata,
  input wire logic regAck,
  input wire logic loaderAbort,
  input wire logic loaderReload,
  input wire logic vphyResetOut,
  input wire logic phy1ResetOut,
  input wire logic phy2ResetOut,
  input wire logic coreResetOut,
  input wire logic deviceReady
);
  localparam int CORE_LO = CORE_HOLD - 2;
  localparam int CORE_HI = CORE_HOLD + 4;
  localparam int VPHY_LO = VPHY_HOLD - 10;
  localparam int VPHY_HI = VPHY_HOLD - 4;
  logic [15:0] holdCnt_q;
  logic resetWr;
  assign resetWr = regReq && regWrite && regAddr == OFS_SOFT_RESET && regHalf[0];
  // The port hold is far too long for a repetition, so it is counted here.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      holdCnt_q <= 16'h0000;
    end else begin
      holdCnt_q <= phy1ResetOut ? holdCnt_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ack;
    regReq |=> regAck;
  endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged");
  property p_core;
    resetWr && !regLoader && regWdata[0] && !coreResetOut |=> coreResetOut && loaderAbort;
  endproperty
  a_core: assert property (p_core) else $error("core reset not started");
  property p_loader;
    resetWr && regLoader |=> !$rose(vphyResetOut || phy1ResetOut || phy2ResetOut || coreResetOut);
  endproperty
  a_loader: assert property (p_loader) else $error("loader started a reset");
  property p_hold;
    $fell(phy1ResetOut) |-> holdCnt_q >= PHY_HOLD && holdCnt_q <= PHY_HOLD + 2;
  endproperty
  a_hold: assert property (p_hold) else $error("port hold length wrong");
  property p_vphy;
    $rose(vphyResetOut) |-> vphyResetOut[*8] ##[VPHY_LO:VPHY_HI] !vphyResetOut;
  endproperty
  a_vphy: assert property (p_vphy) else $error("virtual reset hold wrong");
  property p_coreEnd;
    $rose(coreResetOut) |-> ##[CORE_LO:CORE_HI] !coreResetOut;
  endproperty
  a_coreEnd: assert property (p_coreEnd) else $error("core reset not cleared");
  property p_reload;
    $fell(coreResetOut) |-> ##[0:1] loaderReload;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload after core reset");
  property p_notReady;
    $rose(coreResetOut) |-> ##[0:2] !deviceReady;
  endproperty
  a_notReady: assert property (p_notReady) else $error("ready kept in reset");
  property p_ready;
    $rose(deviceReady) |-> !coreResetOut;
  endproperty
  a_ready: assert property (p_ready) else $error("ready during core reset");
endmodule

/* File: tb/tsrc_regs_tb_top.sv */
// Self-checking bench for the timer, tick counter and soft reset registers.
`timescale 1ns/1ps
bind tsrc_regs tsrc_regs_properties #(.PHY_HOLD(PHY_HOLD), .VPHY_HOLD(VPHY_HOLD),
  .CORE_HOLD(CORE_HOLD)) u_props (.clk, .rst_b, .regReq, .regWrite, .regLoader, .regAddr,
  .regHalf, .regWdata, .regAck, .loaderAbort, .loaderReload, .vphyResetOut, .phy1ResetOut,
  .phy2ResetOut, .coreResetOut, .deviceReady);
module tsrc_regs_tb_top;
  import tsrc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic regReq = 1'b0;
  logic regWrite = 1'b0;
  logic regLoader = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [1:0] regHalf = 2'h3;
  logic [31:0] regWdata = 32'h00000000;
  logic [31:0] regRdata, rd, t0, pins;
  logic regAck, timerEvent, vphyResetOut, phy1ResetOut, phy2ResetOut, coreResetOut;
  logic loaderAbort, loaderReload, deviceReady;
  int fail_count = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  // The reset pins packed in the same bit order as the request register.
  assign pins = {28'h0000000, vphyResetOut, phy2ResetOut, phy1ResetOut, coreResetOut};
  // A short port hold and a fast timer keep the run brief.
  tsrc_regs #(.PHY_HOLD(20), .TIMER_DIV(4)) u_dut (.clk, .rst_b, .regReq, .regWrite,
    .regLoader, .regAddr, .regHalf, .regWdata, .regAck, .regRdata, .timerEvent,
    .vphyResetOut, .phy1ResetOut, .phy2ResetOut, .coreResetOut, .loaderAbort,
    .loaderReload, .deviceReady);
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic ld, input logic [11:0] a, input logic [1:0] h,
    input logic [31:0] d);
    @(posedge clk);
    regWrite <= w;
    regLoader <= ld;
    regAddr <= a;
    regHalf <= h;
    regWdata <= d;
    regReq <= 1'b1;
    @(posedge clk);
    regReq <= 1'b0;
    #1;
    chk("ack", 32'h1, 32'(regAck));
    rd = regRdata;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [1:0] h, input logic [31:0] exp,
    input string what);
    acc(1'b0, 1'b0, a, h, 32'h00000000);
    chk(what, exp, rd);
  endtask
  initial begin
    int n;
    logic seen;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rdc(OFS_SOFT_RESET, 2'h3, READ_ZERO, "early reset control");
    acc(1'b0, 1'b0, OFS_TICK_COUNTER, 2'h3, 32'h00000000);
    chk("tick cleared", 32'h1, 32'(rd < 32'h00000004));
    for (n = 0; n < 100 && !deviceReady; n++) begin
      @(posedge clk);
      #1;
    end
    chk("ready", 32'h1, 32'(deviceReady));
    rdc(OFS_BYTE_PROBE, 2'h3, BYTE_PROBE_VALUE, "probe");
    rdc(OFS_BYTE_PROBE, 2'h1, 32'h00004321, "probe low half");
    rdc(OFS_BYTE_PROBE, 2'h2, 32'h87650000, "probe high half");
    rdc(OFS_HW_CONFIG, 2'h3, 32'h08000000, "hw config");
    rdc(12'h100, 2'h3, READ_ZERO, "unmapped");
    rdc(OFS_TIMER_CONFIG, 2'h3, 32'h0000FFFF, "config default");
    acc(1'b1, 1'b0, OFS_TIMER_COUNT, 2'h3, 32'h00001234);
    rdc(OFS_TIMER_COUNT, 2'h3, 32'h0000FFFF, "count read only");
    acc(1'b0, 1'b0, OFS_TICK_COUNTER, 2'h3, 32'h00000000);
    t0 = rd;
    repeat (98) @(posedge clk);
    rdc(OFS_TICK_COUNTER, 2'h3, t0 + 32'h0000000A, "tick step");
    $display("Test reset values done");
    acc(1'b1, 1'b0, OFS_TIMER_CONFIG, 2'h3, 32'h20000003);
    acc(1'b0, 1'b0, OFS_TIMER_COUNT, 2'h3, 32'h00000000);
    chk("timer start", 32'h1, 32'(rd[15:0] <= 16'h0003));
    seen = 1'b0;
    for (n = 0; n < 60 && !seen; n++) begin
      @(posedge clk);
      #1;
      seen = timerEvent;
    end
    chk("timer event", 32'h1, 32'(seen));
    acc(1'b0, 1'b0, OFS_TIMER_COUNT, 2'h3, 32'h00000000);
    chk("timer wrap", 32'h1, 32'(rd[15:0] >= 16'hFFFE));
    acc(1'b1, 1'b0, OFS_TIMER_CONFIG, 2'h2, 32'h00000000);
    rdc(OFS_TIMER_CONFIG, 2'h3, 32'h0000FFFF, "preload forced");
    acc(1'b0, 1'b0, OFS_TIMER_COUNT, 2'h3, 32'h00000000);
    t0 = rd;
    repeat (20) @(posedge clk);
    rdc(OFS_TIMER_COUNT, 2'h3, t0, "timer halted");
    $display("Test timer done");
    for (n = 1; n < 4; n++) begin
      acc(1'b1, 1'b0, OFS_SOFT_RESET, 2'h3, 32'(1) << n);
      rdc(OFS_SOFT_RESET, 2'h3, 32'(1) << n, "request set");
      chk("reset pins", 32'(1) << n, pins);
      acc(1'b1, 1'b0, OFS_SOFT_RESET, 2'h3, 32'h00000000);
      rdc(OFS_SOFT_RESET, 2'h3, 32'(1) << n, "write ignored");
      repeat (40) @(posedge clk);
      rdc(OFS_SOFT_RESET, 2'h3, READ_ZERO, "self clear");
      chk("reset pins clear", READ_ZERO, pins);
      acc(1'b1, 1'b1, OFS_SOFT_RESET, 2'h3, 32'(1) << n);
      rdc(OFS_SOFT_RESET, 2'h3, READ_ZERO, "loader refused");
    end
    acc(1'b1, 1'b0, OFS_TIMER_CONFIG, 2'h3, 32'h00000055);
    acc(1'b1, 1'b0, OFS_SOFT_RESET, 2'h3, 32'h00000001);
    chk("abort", 32'h1, 32'(loaderAbort));
    chk("core reset", 32'h1, 32'(coreResetOut));
    rdc(OFS_BYTE_PROBE, 2'h3, READ_ZERO, "probe in core reset");
    rdc(OFS_TICK_COUNTER, 2'h3, TICK_RESET, "tick after core reset");
    seen = 1'b0;
    for (n = 0; n < 200 && !(seen && deviceReady); n++) begin
      @(posedge clk);
      #1;
      seen = seen | loaderReload;
    end
    chk("reload", 32'h1, 32'(seen));
    chk("ready again", 32'h1, 32'(deviceReady));
    // The host learns that the core reset is over by polling the probe.
    rd = READ_ZERO;
    for (n = 0; n < 8 && rd !== BYTE_PROBE_VALUE; n++) begin
      acc(1'b0, 1'b0, OFS_BYTE_PROBE, 2'h3, READ_ZERO);
    end
    chk("probe after core reset", BYTE_PROBE_VALUE, rd);
    rdc(OFS_TIMER_CONFIG, 2'h3, 32'h0000FFFF, "config restored");
    rdc(OFS_SOFT_RESET, 2'h3, READ_ZERO, "core bit clear");
    $display("Test soft reset done");
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule
